// File: logic/rtu_pkg.sv
package rtu_pkg;
    // system clock
    localparam int CLK_HZ = 20_000_000;

    // bit rate selection codes
    localparam logic [2:0] RATE_9600 = 3'h0;
    localparam logic [2:0] RATE_19200 = 3'h1;
    localparam logic [2:0] RATE_38400 = 3'h2;
    localparam logic [2:0] RATE_57600 = 3'h3;
    localparam logic [2:0] RATE_115200 = 3'h4;
    localparam logic [2:0] RATE_230400 = 3'h5;

    // parity selection codes
    localparam logic [1:0] PAR_NONE = 2'h0;
    localparam logic [1:0] PAR_EVEN = 2'h1;
    localparam logic [1:0] PAR_ODD = 2'h2;

    localparam int DIV_W = 12;
    localparam logic [DIV_W-1:0] DIV_9600 = DIV_W'(CLK_HZ / 9600);
    localparam logic [DIV_W-1:0] DIV_19200 = DIV_W'(CLK_HZ / 19200);
    localparam logic [DIV_W-1:0] DIV_38400 = DIV_W'(CLK_HZ / 38400);
    localparam logic [DIV_W-1:0] DIV_57600 = DIV_W'(CLK_HZ / 57600);
    localparam logic [DIV_W-1:0] DIV_115200 = DIV_W'(CLK_HZ / 115200);
    localparam logic [DIV_W-1:0] DIV_230400 = DIV_W'(CLK_HZ / 230400);

    // inter_frame_idle_gap in automatic mode
    localparam int GAP_LOW_RATE_US = 4000;
    localparam int GAP_HIGH_RATE_US = 2500;
    localparam int GAP_LOW_RATE_CYC = GAP_LOW_RATE_US * (CLK_HZ / 1_000_000);
    localparam int GAP_HIGH_RATE_CYC = GAP_HIGH_RATE_US * (CLK_HZ / 1_000_000);
    // unit of manual gap and reply_holdoff_time settings
    localparam int TICK_US = 100;
    localparam int TICK_CYC = TICK_US * (CLK_HZ / 1_000_000);
    // unit of query_gap_timeout
    localparam int MS_US = 1000;
    localparam int MS_CYC = MS_US * (CLK_HZ / 1_000_000);

    localparam int CNT_W = 20;
    localparam logic [7:0] BROADCAST_ADDR = 8'h00;
    localparam int MAX_FRAME = 256;
    localparam int MIN_FRAME = 4;
    localparam logic [15:0] CRC_INIT = 16'hffff;
    localparam logic [15:0] CRC_POLY = 16'ha001;

    function automatic logic [DIV_W-1:0] baud_div(input logic [2:0] sel);
        unique case (sel)
            RATE_9600: baud_div = DIV_9600;
            RATE_19200: baud_div = DIV_19200;
            RATE_38400: baud_div = DIV_38400;
            RATE_57600: baud_div = DIV_57600;
            RATE_115200: baud_div = DIV_115200;
            default: baud_div = DIV_230400;
        endcase
    endfunction : baud_div

    function automatic logic [15:0] crc_byte(input logic [15:0] crc,
                                             input logic [7:0] data);
        logic [15:0] c;
        c = crc ^ {8'h00, data};
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        end
        crc_byte = c;
    endfunction : crc_byte
endpackage : rtu_pkg

// File: logic/char_if.sv
`timescale 1ns/10ps
`default_nettype none
interface char_if;
    logic [2:0] rate_sel;
    logic [1:0] parity_sel;
    logic two_stop;
    logic [7:0] rx_data;
    logic rx_strobe;
    logic rx_err;
    logic rx_active;
    logic [7:0] tx_data;
    logic tx_start;
    logic tx_busy;

    modport engine (
        input rate_sel, parity_sel, two_stop, tx_data, tx_start,
        output rx_data, rx_strobe, rx_err, rx_active, tx_busy
    );
    modport framer (
        output rate_sel, parity_sel, two_stop, tx_data, tx_start,
        input rx_data, rx_strobe, rx_err, rx_active, tx_busy
    );
endinterface : char_if
`default_nettype wire

// File: logic/serial_char_port.sv
`timescale 1ns/10ps
`default_nettype none
module serial_char_port (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // line
    input wire logic rx_pin,
    output logic tx_pin,
    // framer side
    char_if.engine cif
);
    import rtu_pkg::*;

    typedef enum logic {E_IDLE = 1'b0, E_RUN = 1'b1} eng_state_t;

    logic rx_m_q, rx_s_q;
    eng_state_t rx_st_q, rx_st_d, tx_st_q, tx_st_d;
    logic [DIV_W-1:0] rx_cnt_q, rx_cnt_d, tx_cnt_q, tx_cnt_d, div;
    logic [3:0] rx_idx_q, rx_idx_d, tx_idx_q, tx_idx_d, rx_last, tx_last;
    logic [7:0] rx_sh_q, rx_sh_d;
    logic rx_err_q, rx_err_d, strobe_d, par_en, odd;
    logic [11:0] tx_sh_q, tx_sh_d;

    assign div = baud_div(cif.rate_sel);
    assign par_en = cif.parity_sel != PAR_NONE;
    assign odd = cif.parity_sel == PAR_ODD;
    assign rx_last = 4'h8 + {3'h0, par_en} + (cif.two_stop ? 4'h2 : 4'h1);
    assign tx_last = rx_last;

    always_comb begin
        rx_st_d = rx_st_q;
        rx_cnt_d = rx_cnt_q;
        rx_idx_d = rx_idx_q;
        rx_sh_d = rx_sh_q;
        rx_err_d = rx_err_q;
        strobe_d = 1'b0;
        unique case (rx_st_q)
            E_IDLE: begin
                if (!rx_s_q) begin
                    rx_st_d = E_RUN;
                    rx_cnt_d = div >> 1;
                    rx_idx_d = 4'h0;
                    rx_err_d = 1'b0;
                end
            end
            E_RUN: begin
                if (rx_cnt_q != '0) begin
                    rx_cnt_d = rx_cnt_q - 1'b1;
                end else begin
                    rx_cnt_d = div;
                    rx_idx_d = rx_idx_q + 1'b1;
                    if (rx_idx_q == 4'h0) begin
                        // a start glitch shorter than half a bit is no char
                        if (rx_s_q) begin
                            rx_st_d = E_IDLE;
                        end
                    end else if (rx_idx_q <= 4'h8) begin
                        rx_sh_d = {rx_s_q, rx_sh_q[7:1]};
                    end else if (par_en && rx_idx_q == 4'h9) begin
                        if ((^rx_sh_q ^ rx_s_q) != odd) begin
                            rx_err_d = 1'b1;
                        end
                    end else if (!rx_s_q) begin
                        rx_err_d = 1'b1;
                    end
                    if (rx_idx_q == rx_last) begin
                        rx_st_d = E_IDLE;
                        strobe_d = 1'b1;
                        rx_err_d = rx_err_q | !rx_s_q;
                    end
                end
            end
        endcase
    end

    always_comb begin
        tx_st_d = tx_st_q;
        tx_cnt_d = tx_cnt_q;
        tx_idx_d = tx_idx_q;
        tx_sh_d = tx_sh_q;
        unique case (tx_st_q)
            E_IDLE: begin
                if (cif.tx_start) begin
                    tx_st_d = E_RUN;
                    tx_cnt_d = div;
                    tx_idx_d = 4'h0;
                    tx_sh_d = par_en ?
                        {2'b11, ^cif.tx_data ^ odd, cif.tx_data, 1'b0} :
                        {3'b111, cif.tx_data, 1'b0};
                end
            end
            E_RUN: begin
                if (tx_cnt_q != '0) begin
                    tx_cnt_d = tx_cnt_q - 1'b1;
                end else begin
                    tx_cnt_d = div;
                    tx_idx_d = tx_idx_q + 1'b1;
                    tx_sh_d = {1'b1, tx_sh_q[11:1]};
                    if (tx_idx_q == tx_last) begin
                        tx_st_d = E_IDLE;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rx_m_q <= 1'b1;
            rx_s_q <= 1'b1;
            rx_st_q <= E_IDLE;
            rx_cnt_q <= '0;
            rx_idx_q <= 4'h0;
            rx_sh_q <= 8'h00;
            rx_err_q <= 1'b0;
            cif.rx_strobe <= 1'b0;
            tx_st_q <= E_IDLE;
            tx_cnt_q <= '0;
            tx_idx_q <= 4'h0;
            tx_sh_q <= 12'hfff;
        end else begin
            rx_m_q <= rx_pin;
            rx_s_q <= rx_m_q;
            rx_st_q <= rx_st_d;
            rx_cnt_q <= rx_cnt_d;
            rx_idx_q <= rx_idx_d;
            rx_sh_q <= rx_sh_d;
            rx_err_q <= rx_err_d;
            cif.rx_strobe <= strobe_d;
            tx_st_q <= tx_st_d;
            tx_cnt_q <= tx_cnt_d;
            tx_idx_q <= tx_idx_d;
            tx_sh_q <= tx_sh_d;
        end
    end

    assign cif.rx_data = rx_sh_q;
    assign cif.rx_err = rx_err_q;
    assign cif.rx_active = rx_st_q == E_RUN;
    assign cif.tx_busy = tx_st_q == E_RUN;
    assign tx_pin = tx_sh_q[0];
endmodule : serial_char_port
`default_nettype wire

// File: logic/modbus_rtu_slave_link.sv
// Function
// - single master; slave only answers queries, never speaks unsolicited
// - only binary RTU framing is decoded, no ASCII mode
// - unicast query to own address is processed then answered
// - address 0 is broadcast: executed, never answered
// - 8 data bits, one or two stop bits, none/even/odd parity
// - rate 9600 to 230400 bps, same on both ends
// - no query within the timeout raises a timeout alarm
// - timeout restarts on every good frame, any address
// - enable driver, then reply after gap, processing and holdoff time
// - automatic gap is 4 ms at low rates, 2.5 ms at high
// - frames with too short a gap are dropped and error flagged
// - 16-bit CRC from all ones, right shift, reflected polynomial
// - framing, parity or CRC errors drop the query silently
// - frames longer than 256 bytes are dropped silently
// - no reply when the address differs from own address
`timescale 1ns/10ps
`default_nettype none
module modbus_rtu_slave_link #(
    parameter int GAP_LOW_CYC = rtu_pkg::GAP_LOW_RATE_CYC,
    parameter int GAP_HIGH_CYC = rtu_pkg::GAP_HIGH_RATE_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // rs-485 line
    input wire logic rx_pin,
    output logic tx_pin,
    output logic driver_en,
    // configuration
    input wire logic [7:0] own_addr,
    input wire logic [2:0] rate_sel,
    input wire logic [1:0] parity_sel,
    input wire logic two_stop,
    input wire logic [7:0] inter_frame_idle_gap,
    input wire logic [7:0] reply_holdoff_time,
    input wire logic [15:0] query_gap_timeout,
    // status
    output logic timeout_alarm,
    input wire logic timeout_alarm_clr,
    output logic comm_error,
    output logic frame_dropped,
    output logic frame_broadcast,
    // query bytes to the application
    output logic [7:0] q_data,
    output logic q_last,
    output logic q_valid,
    input wire logic q_ready,
    // response bytes from the application
    input wire logic [7:0] r_data,
    input wire logic r_last,
    input wire logic r_valid,
    output logic r_ready
);
    import rtu_pkg::*;

    typedef enum logic [2:0] {
        S_RECV = 3'b000,
        S_DELIVER = 3'b001,
        S_PROCESS = 3'b011,
        S_HOLD = 3'b010,
        S_SEND = 3'b110,
        S_CRC = 3'b111,
        S_DRAIN = 3'b101
    } link_state_t;

    char_if cif ();

    serial_char_port u_port (
        .clk(clk),
        .reset_n(reset_n),
        .rx_pin(rx_pin),
        .tx_pin(tx_pin),
        .cif(cif)
    );

    assign cif.rate_sel = rate_sel;
    assign cif.parity_sel = parity_sel;
    assign cif.two_stop = two_stop;

    logic [7:0] mem [MAX_FRAME];
    link_state_t st_q, st_d;
    logic [CNT_W-1:0] idle_q, idle_d, hold_q, hold_d, gap_cyc, hold_cyc;
    logic [8:0] len_q, len_d, rd_q, rd_d;
    logic [15:0] crc_q, crc_d, tcrc_q, tcrc_d;
    logic bad_q, bad_d, late_q, late_d, crc_hi_q, crc_hi_d;
    logic gap_done, frame_end, good, mine, accept, push;
    logic drop_d, err_d, bc_q, bc_d, de_d, rdy_d, start_q, start_d;
    logic [7:0] txd_q, txd_d;
    logic [14:0] ms_cyc_q, ms_cyc_d;
    logic [15:0] ms_q, ms_d;
    logic alarm_d;
    logic [7:0] sk_data_q, sk_data_d, o_data_d;
    logic sk_last_q, sk_last_d, sk_valid_q, sk_valid_d;
    logic o_last_d, o_valid_d;

    always_comb begin
        if (inter_frame_idle_gap != 8'h00) begin
            gap_cyc = CNT_W'(inter_frame_idle_gap * TICK_CYC);
        end else if (rate_sel <= RATE_38400) begin
            gap_cyc = CNT_W'(GAP_LOW_CYC);
        end else begin
            gap_cyc = CNT_W'(GAP_HIGH_CYC);
        end
    end
    assign hold_cyc = CNT_W'(reply_holdoff_time * TICK_CYC);

    // idle time since the last character on the line
    assign gap_done = !cif.rx_active && idle_q >= gap_cyc;
    assign frame_end = st_q == S_RECV && len_q != 9'h000 && gap_done;
    // binary crc check over the whole frame leaves zero
    assign good = !bad_q && !late_q && len_q >= 9'(MIN_FRAME) &&
        len_q <= 9'(MAX_FRAME) && crc_q == 16'h0000;
    assign mine = mem[0] == own_addr || mem[0] == BROADCAST_ADDR;
    assign accept = r_valid && r_ready;
    assign push = st_q == S_DELIVER && !sk_valid_q;

    always_comb begin
        st_d = st_q;
        idle_d = (cif.rx_active || cif.rx_strobe) ? '0 : idle_q;
        if (idle_d != {CNT_W{1'b1}} && !cif.rx_active) begin
            idle_d = idle_q + 1'b1;
        end
        len_d = len_q;
        crc_d = crc_q;
        bad_d = bad_q;
        late_d = late_q;
        rd_d = rd_q;
        hold_d = hold_q;
        tcrc_d = tcrc_q;
        crc_hi_d = crc_hi_q;
        drop_d = 1'b0;
        err_d = 1'b0;
        bc_d = bc_q;
        de_d = driver_en;
        start_d = 1'b0;
        txd_d = txd_q;
        if (cif.rx_strobe) begin
            if (st_q == S_RECV && !late_q) begin
                if (len_q != 9'(MAX_FRAME + 1)) begin
                    len_d = len_q + 1'b1;
                end
                crc_d = crc_byte(crc_q, cif.rx_data);
                bad_d = bad_q | cif.rx_err;
            end else if (!late_q) begin
                late_d = 1'b1;
                err_d = 1'b1;
            end
        end
        unique case (st_q)
            S_RECV: begin
                if (frame_end) begin
                    len_d = (good && mine) ? len_q : 9'h000;
                    crc_d = CRC_INIT;
                    bad_d = 1'b0;
                    late_d = 1'b0;
                    rd_d = 9'h000;
                    drop_d = !good;
                    if (good && mine) begin
                        st_d = S_DELIVER;
                        bc_d = mem[0] == BROADCAST_ADDR;
                    end
                end else if (late_q && len_q == 9'h000 && gap_done) begin
                    late_d = 1'b0;
                end
            end
            S_DELIVER: begin
                if (push) begin
                    rd_d = rd_q + 1'b1;
                    if (rd_q == len_q - 9'h003) begin
                        // broadcast is executed but never answered
                        st_d = bc_q ? S_RECV : S_PROCESS;
                        len_d = 9'h000;
                    end
                end
            end
            S_PROCESS: begin
                if (r_valid) begin
                    st_d = S_HOLD;
                    de_d = 1'b1;
                    hold_d = '0;
                    tcrc_d = CRC_INIT;
                end
            end
            S_HOLD: begin
                hold_d = hold_q + 1'b1;
                if (hold_q >= hold_cyc) begin
                    st_d = S_SEND;
                end
            end
            S_SEND: begin
                if (accept) begin
                    start_d = 1'b1;
                    txd_d = r_data;
                    tcrc_d = crc_byte(tcrc_q, r_data);
                    crc_hi_d = 1'b0;
                    if (r_last) begin
                        st_d = S_CRC;
                    end
                end
            end
            S_CRC: begin
                // crc goes out low byte first
                if (!cif.tx_busy && !start_q) begin
                    start_d = 1'b1;
                    txd_d = crc_hi_q ? tcrc_q[15:8] : tcrc_q[7:0];
                    crc_hi_d = 1'b1;
                    if (crc_hi_q) begin
                        st_d = S_DRAIN;
                    end
                end
            end
            S_DRAIN: begin
                if (!cif.tx_busy && !start_q) begin
                    st_d = S_RECV;
                    de_d = 1'b0;
                    idle_d = '0;
                end
            end
            default: st_d = S_RECV;
        endcase
        // app sees one byte per character slot, so no byte is ever queued
        rdy_d = st_d == S_SEND && st_q == S_SEND && !cif.tx_busy &&
            !start_q && !start_d && !r_ready;
    end

    always_comb begin
        sk_data_d = sk_data_q;
        sk_last_d = sk_last_q;
        sk_valid_d = sk_valid_q;
        o_data_d = q_data;
        o_last_d = q_last;
        o_valid_d = q_valid;
        if (!q_valid || q_ready) begin
            if (sk_valid_q) begin
                o_data_d = sk_data_q;
                o_last_d = sk_last_q;
                o_valid_d = 1'b1;
                sk_valid_d = 1'b0;
            end else if (push) begin
                o_data_d = mem[rd_q[7:0]];
                o_last_d = rd_q == len_q - 9'h003;
                o_valid_d = 1'b1;
            end else begin
                o_valid_d = 1'b0;
            end
        end else if (push) begin
            sk_data_d = mem[rd_q[7:0]];
            sk_last_d = rd_q == len_q - 9'h003;
            sk_valid_d = 1'b1;
        end
    end

    always_comb begin
        ms_cyc_d = ms_cyc_q + 1'b1;
        ms_d = ms_q;
        alarm_d = timeout_alarm && !timeout_alarm_clr;
        if (ms_cyc_q == 15'(MS_CYC - 1)) begin
            ms_cyc_d = '0;
            if (ms_q != 16'hffff) begin
                ms_d = ms_q + 1'b1;
            end
        end
        if (query_gap_timeout != 16'h0000 && ms_q >= query_gap_timeout) begin
            alarm_d = 1'b1;
            ms_d = 16'h0000;
        end
        if (frame_end && good) begin
            ms_cyc_d = '0;
            ms_d = 16'h0000;
        end
    end

    always_ff @(posedge clk) begin
        if (cif.rx_strobe && st_q == S_RECV && len_q < 9'(MAX_FRAME)) begin
            mem[len_q[7:0]] <= cif.rx_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            st_q <= S_RECV;
            idle_q <= '0;
            len_q <= 9'h000;
            crc_q <= CRC_INIT;
            bad_q <= 1'b0;
            late_q <= 1'b0;
            rd_q <= 9'h000;
            hold_q <= '0;
            tcrc_q <= CRC_INIT;
            crc_hi_q <= 1'b0;
            bc_q <= 1'b0;
            start_q <= 1'b0;
            txd_q <= 8'h00;
            driver_en <= 1'b0;
            r_ready <= 1'b0;
            frame_dropped <= 1'b0;
            comm_error <= 1'b0;
            sk_data_q <= 8'h00;
            sk_last_q <= 1'b0;
            sk_valid_q <= 1'b0;
            q_data <= 8'h00;
            q_last <= 1'b0;
            q_valid <= 1'b0;
            ms_cyc_q <= '0;
            ms_q <= 16'h0000;
            timeout_alarm <= 1'b0;
        end else begin
            st_q <= st_d;
            idle_q <= idle_d;
            len_q <= len_d;
            crc_q <= crc_d;
            bad_q <= bad_d;
            late_q <= late_d;
            rd_q <= rd_d;
            hold_q <= hold_d;
            tcrc_q <= tcrc_d;
            crc_hi_q <= crc_hi_d;
            bc_q <= bc_d;
            start_q <= start_d;
            txd_q <= txd_d;
            driver_en <= de_d;
            r_ready <= rdy_d;
            frame_dropped <= drop_d;
            comm_error <= err_d;
            sk_data_q <= sk_data_d;
            sk_last_q <= sk_last_d;
            sk_valid_q <= sk_valid_d;
            q_data <= o_data_d;
            q_last <= o_last_d;
            q_valid <= o_valid_d;
            ms_cyc_q <= ms_cyc_d;
            ms_q <= ms_d;
            timeout_alarm <= alarm_d;
        end
    end

    assign frame_broadcast = bc_q;
    assign cif.tx_start = start_q;
    assign cif.tx_data = txd_q;
endmodule : modbus_rtu_slave_link
`default_nettype wire

// File: testbench/modbus_rtu_slave_link_properties.sv
`timescale 1ns/10ps
`default_nettype none
module link_checker (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // line
    input wire logic tx_pin,
    input wire logic driver_en,
    // status
    input wire logic [15:0] query_gap_timeout,
    input wire logic timeout_alarm,
    input wire logic timeout_alarm_clr,
    input wire logic frame_dropped,
    input wire logic frame_broadcast,
    // streams
    input wire logic [7:0] q_data,
    input wire logic q_valid,
    input wire logic q_ready,
    input wire logic r_valid,
    input wire logic r_ready
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_idle_mark: assert property (!driver_en |-> tx_pin)
        else $error("tx line low while driver off");
    a_hold_query: assert property (q_valid && !q_ready |=>
        q_valid && $stable(q_data)) else $error("query byte not held");
    a_bcast_silent: assert property (frame_broadcast |-> !r_ready)
        else $error("reply accepted for broadcast");
    a_ready_driven: assert property (r_ready |-> driver_en)
        else $error("reply taken with driver off");
    a_driver_cause: assert property ($rose(driver_en) |-> $past(r_valid))
        else $error("driver enabled without a reply");
    a_holdoff_idle: assert property ($rose(driver_en) |-> tx_pin [*3])
        else $error("reply started without holdoff");
    a_drop_silent: assert property (frame_dropped |=>
        (!frame_dropped && !q_valid) [*4]) else $error("dropped frame leaked");
    a_alarm_held: assert property (timeout_alarm && !timeout_alarm_clr
        |=> timeout_alarm) else $error("alarm lost without clear");
    a_alarm_off: assert property (query_gap_timeout == 16'h0000
        && !timeout_alarm |=> !timeout_alarm) else $error("alarm while off");
endmodule : link_checker
bind modbus_rtu_slave_link link_checker u_chk (.clk, .reset_n, .tx_pin,
    .driver_en, .query_gap_timeout, .timeout_alarm, .timeout_alarm_clr,
    .frame_dropped, .frame_broadcast, .q_data, .q_valid, .q_ready, .r_valid,
    .r_ready);
`default_nettype wire

// File: testbench/modbus_master_model.sv
`timescale 1ns/10ps
`default_nettype none
module modbus_master_model #(
    parameter int BIT_CYC = 87
) (
    // clock
    input wire logic clk,
    // line
    input wire logic tx_pin,
    output logic rx_pin
);
    // biased bus rests high between frames
    initial rx_pin = 1'b1;

    function automatic logic [15:0] next_crc(input logic [15:0] c,
                                             input logic [7:0] b);
        c = c ^ {8'h00, b};
        for (int k = 0; k < 8; k++) begin
            c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
        end
        return c;
    endfunction : next_crc

    // start, eight data bits lsb first, one stop, no parity
    task automatic put_char(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rx_pin = f[i];
            repeat (BIT_CYC) @(negedge clk);
        end
    endtask : put_char

    // only the master opens a transfer
    task automatic send(input logic [7:0] q[$], input logic bad);
        logic [15:0] c;
        c = 16'hffff;
        foreach (q[i]) begin
            put_char(q[i]);
            c = next_crc(c, q[i]);
        end
        put_char(c[7:0] ^ {7'h00, bad});
        put_char(c[15:8]);
    endtask : send

    task automatic get_char(output logic [7:0] b);
        @(negedge clk iff tx_pin === 1'b0);
        repeat (BIT_CYC / 2) @(negedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(negedge clk);
            b[i] = tx_pin;
        end
        repeat (BIT_CYC) @(negedge clk);
    endtask : get_char
endmodule : modbus_master_model
`default_nettype wire

// File: testbench/modbus_rtu_slave_link_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module modbus_rtu_slave_link_tb_top;
    import rtu_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic rx_pin, tx_pin, driver_en;
    logic [7:0] own_addr = 8'h11;
    logic [2:0] rate_sel = RATE_230400;
    logic [1:0] parity_sel = PAR_NONE;
    logic two_stop = 1'b0;
    logic [7:0] inter_frame_idle_gap = 8'h00;
    logic [7:0] reply_holdoff_time = 8'h01;
    logic [15:0] query_gap_timeout = 16'h0000;
    logic timeout_alarm, comm_error, frame_dropped, frame_broadcast;
    logic timeout_alarm_clr = 1'b0;
    logic [7:0] q_data;
    logic q_last, q_valid;
    logic q_ready = 1'b0;
    logic [7:0] r_data = 8'h00;
    logic r_last = 1'b0;
    logic r_valid = 1'b0;
    logic r_ready;
    logic [7:0] got[$];
    int last_at = -1;
    int drops = 0, cerrs = 0;
    int errors = 0;
    int n_checks = 0;

    modbus_rtu_slave_link #(.GAP_LOW_CYC(3200), .GAP_HIGH_CYC(2000)) u_dut (
        .clk, .reset_n, .rx_pin, .tx_pin, .driver_en, .own_addr, .rate_sel,
        .parity_sel, .two_stop, .inter_frame_idle_gap, .reply_holdoff_time,
        .query_gap_timeout, .timeout_alarm, .timeout_alarm_clr,
        .comm_error, .frame_dropped, .frame_broadcast, .q_data, .q_last,
        .q_valid, .q_ready, .r_data, .r_last, .r_valid, .r_ready);
    modbus_master_model u_master (.clk, .tx_pin, .rx_pin);

    always #25 clk = ~clk;
    // stall every other cycle so the two-entry buffer fills
    always @(negedge clk) q_ready <= ~q_ready;
    always @(posedge clk) begin
        if (q_valid && q_ready && q_last) last_at = got.size();
        if (q_valid && q_ready) got.push_back(q_data);
        if (frame_dropped) drops++;
        if (comm_error) cerrs++;
    end

    task automatic check(input logic [15:0] g, input logic [15:0] e);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : check

    task automatic deliver(input logic [7:0] q[$], input logic bad);
        got.delete();
        u_master.send(q, bad);
        repeat (2300) @(negedge clk);
    endtask : deliver

    task automatic answer(input logic [7:0] q[$]);
        foreach (q[i]) begin
            r_valid <= 1'b1;
            r_data <= q[i];
            r_last <= (i == q.size() - 1);
            do @(posedge clk); while (r_ready !== 1'b1);
            @(negedge clk);
        end
        r_valid <= 1'b0;
        r_last <= 1'b0;
    endtask : answer

    task automatic t_unicast;
        logic [7:0] rsp[$], b;
        logic [15:0] c;
        rsp = '{8'h11, 8'h03, 8'h02};
        c = 16'hffff;
        deliver('{8'h11, 8'h03, 8'h00, 8'h01}, 1'b0);
        check(got.size(), 4);
        check(got[3], 8'h01);
        check(last_at, 3);
        check(frame_broadcast, 1'b0);
        fork
            answer(rsp);
            u_master.put_char(8'h55);
            for (int i = 0; i < 5; i++) begin
                u_master.get_char(b);
                if (i < 3) check(b, rsp[i]);
                if (i < 3) c = u_master.next_crc(c, b);
                if (i == 3) check(b, c[7:0]);
                if (i == 4) check(b, c[15:8]);
            end
        join
        repeat (2300) @(negedge clk);
        check(driver_en, 1'b0);
        check(cerrs, 1);
        $display("unicast done");
    endtask : t_unicast

    task automatic t_broadcast;
        deliver('{8'h00, 8'h06, 8'h00, 8'h05}, 1'b0);
        check(got.size(), 4);
        check(frame_broadcast, 1'b1);
        check(driver_en, 1'b0);
        $display("broadcast done");
    endtask : t_broadcast

    task automatic t_foreign;
        inter_frame_idle_gap <= 8'h01;
        deliver('{8'h22, 8'h03, 8'h00, 8'h01}, 1'b0);
        check(got.size(), 0);
        inter_frame_idle_gap <= 8'h00;
        $display("foreign address done");
    endtask : t_foreign

    task automatic t_bad_frames;
        int d;
        d = drops;
        deliver('{8'h11, 8'h03, 8'h00, 8'h01}, 1'b1);
        check(got.size(), 0);
        check(drops != d, 1'b1);
        u_master.send('{8'h11, 8'h06, 8'h00, 8'h02}, 1'b0);
        repeat (200) @(negedge clk);
        deliver('{8'h11, 8'h06, 8'h00, 8'h03}, 1'b0);
        check(got.size(), 0);
        $display("bad frames done");
    endtask : t_bad_frames

    task automatic t_timeout;
        query_gap_timeout <= 16'h0001;
        deliver('{8'h22, 8'h03, 8'h00, 8'h01}, 1'b0);
        timeout_alarm_clr <= 1'b1;
        @(negedge clk);
        timeout_alarm_clr <= 1'b0;
        repeat (15000) @(negedge clk);
        check(timeout_alarm, 1'b0);
        repeat (8000) @(negedge clk);
        check(timeout_alarm, 1'b1);
        query_gap_timeout <= 16'h0000;
        timeout_alarm_clr <= 1'b1;
        repeat (2) @(negedge clk);
        timeout_alarm_clr <= 1'b0;
        check(timeout_alarm, 1'b0);
        $display("timeout done");
    endtask : t_timeout

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_of_test

    initial begin
        repeat (20) @(negedge clk);
        reset_n <= 1'b1;
        repeat (5) @(negedge clk);
        t_unicast();
        t_foreign();
        t_bad_frames();
        t_timeout();
        t_broadcast();
        end_of_test();
    end

    // tests need about 82000 cycles
    initial begin
        repeat (95000) @(negedge clk);
        errors++;
        end_of_test();
    end
endmodule : modbus_rtu_slave_link_tb_top
`default_nettype wire
